// >>> hdl/pin_mux_pkg.sv
// Package with the pin-function encodings, pin bundles and reset timing.
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Function selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        b6_gpio = 2'b00,
        b6_serial_rx = 2'b01,
        b6_i2c_data = 2'b10,
        b6_clock_in = 2'b11
    } line6_func_t;

    typedef enum logic [1:0] {
        b7_gpio = 2'b00,
        b7_serial_tx = 2'b01,
        b7_i2c_clock = 2'b10
    } line7_func_t;

    typedef enum logic [1:0] {
        b4_gpio = 2'b00,
        b4_timer = 2'b01,
        b4_clock_out = 2'b10
    } line4_func_t;

    typedef enum logic [1:0] {
        buffered_clock_out_off = 2'b00,
        buffered_clock_out_master = 2'b01,
        buffered_clock_out_periph = 2'b10,
        buffered_clock_out_osc = 2'b11
    } buffered_clock_out_src_t;

    typedef enum logic [1:0] {
        rst_hold = 2'b00,
        rst_count = 2'b01,
        rst_run = 2'b10
    } rst_state_t;

    // ------------------------------------------------------------
    // Bundles
    // ------------------------------------------------------------
    typedef struct packed {
        line6_func_t line6;
        line7_func_t line7;
        line4_func_t line4;
        logic line1_i2c_data;
        logic reset_pin_gpio;
        buffered_clock_out_src_t buffered_clock_out_src;
    } pin_sel_t;

    // Output value and output enable for one pad.
    typedef struct packed {
        logic out;
        logic oe;
    } pad_drive_t;

    localparam pin_sel_t sel_reset = '{line6: b6_gpio, line7: b7_gpio,
        line4: b4_gpio, line1_i2c_data: 1'b0, reset_pin_gpio: 1'b0,
        buffered_clock_out_src: buffered_clock_out_off};

    localparam int unsigned gpio_count = 5;
    localparam int unsigned idx_b1 = 0;
    localparam int unsigned idx_b4 = 1;
    localparam int unsigned idx_b6 = 2;
    localparam int unsigned idx_b7 = 3;
    localparam int unsigned idx_a7 = 4;

    // Internal reset release delay in internal clock cycles.
    localparam int unsigned rst_release_cycles = 32;
    localparam logic [5:0] rst_count_last = 6'(rst_release_cycles - 1);
endpackage

// >>> hdl/reset_pin_function_mux.sv
// Pin-function multiplexer for the shared port B lines and the reset pin.
// Summary of operation
// [RULE_01] After reset every muxed pin returns to its primary function.
// [RULE_02] Each GPIO pin has its own software direction bit.
// [RULE_03] Port B line 6 defaults to GPIO; other uses need a selection.
// [RULE_04] Line 6 clock input also needs the external clock mode bit.
// [RULE_05] Line 6 in clock-input function is input only, feeding the clock unit.
// [RULE_06] I2C data may be routed to port B line 1 or line 6.
// [RULE_07] Port B line 7 defaults to GPIO; transmit and I2C clock by selection.
// [RULE_08] Line 7 transmit drives data, or is bidirectional in single-wire mode.
// [RULE_09] The reset pin defaults to its reset function.
// [RULE_10] Reset pin low in reset function holds the chip in reset.
// [RULE_11] Internal reset releases synchronously after a fixed cycle count.
// [RULE_12] Reset pin as port A line 7 is input or open-drain only.
// [RULE_13] In GPIO mode external reset is ignored; POR, watchdog, software remain.
// [RULE_14] Port B line 4 defaults to GPIO; timer and clock out by selection.
// [RULE_15] Clock out selects off (logic 0), master, peripheral or oscillator.
// [RULE_16] Selections return to defaults on every chip reset source.
module reset_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic watchdog_reset,
    input wire logic software_reset,
    input wire pin_sel_t sel_wr_data,
    input wire logic sel_wr,
    input wire logic external_clock_mode_bit,
    input wire logic [gpio_count-1:0] gpio_dir_out,
    input wire logic [gpio_count-1:0] gpio_out_data,
    input wire logic [gpio_count-1:0] pad_in,
    input wire logic serial_tx_data,
    input wire logic serial_single_wire,
    input wire logic serial_tx_drive,
    input wire logic i2c_data_oe,
    input wire logic i2c_clock_oe,
    input wire pad_drive_t timer_zero_drive,
    input wire logic master_system_clock,
    input wire logic peripheral_bus_clock,
    input wire logic oscillator_clock,
    output pin_sel_t sel_state_ff,
    output pad_drive_t [gpio_count-1:0] pad_drive_ff,
    output logic [gpio_count-1:0] gpio_in_ff,
    output logic serial_rx_ff,
    output logic i2c_data_in_ff,
    output logic i2c_clock_in_ff,
    output logic timer_zero_in_ff,
    output logic external_clock_in_ff,
    output logic external_clock_valid_ff,
    output logic chip_reset_n_ff
);

    // ------------------------------------------------------------
    // Pad synchronisers
    // ------------------------------------------------------------
    logic [gpio_count-1:0] pad_meta_ff;
    logic [gpio_count-1:0] pad_sync_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_meta_ff <= '1;
            pad_sync_ff <= '1;
        end else begin
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Internal reset sequencer
    // ------------------------------------------------------------
    // The reset pin only counts while it holds its reset function.
    logic pin_reset_req;
    logic any_reset;
    rst_state_t rst_state_ff, nxt_rst_state;
    logic [5:0] rst_cnt_ff, nxt_rst_cnt;
    logic nxt_chip_reset_n;

    assign pin_reset_req = !sel_state_ff.reset_pin_gpio &&
        !pad_sync_ff[idx_a7]; // [RULE_10] [RULE_13]
    assign any_reset = pin_reset_req || watchdog_reset || software_reset;

    always_comb begin
        nxt_rst_state = rst_state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_chip_reset_n = chip_reset_n_ff;
        if (any_reset) begin
            nxt_rst_state = rst_hold; // [RULE_10]
            nxt_rst_cnt = '0;
            nxt_chip_reset_n = 1'b0;
        end else begin
            case (rst_state_ff)
                rst_hold: begin
                    nxt_rst_state = rst_count;
                end
                rst_count: begin
                    if (rst_cnt_ff == rst_count_last) begin
                        nxt_rst_state = rst_run; // [RULE_11]
                        nxt_chip_reset_n = 1'b1;
                    end else begin
                        nxt_rst_cnt = rst_cnt_ff + 6'h01;
                    end
                end
                default: begin
                    nxt_rst_state = rst_run;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_state_ff <= rst_hold;
            rst_cnt_ff <= '0;
            chip_reset_n_ff <= 1'b0;
        end else begin
            rst_state_ff <= nxt_rst_state;
            rst_cnt_ff <= nxt_rst_cnt;
            chip_reset_n_ff <= nxt_chip_reset_n;
        end
    end

    // ------------------------------------------------------------
    // Function selection
    // ------------------------------------------------------------
    pin_sel_t nxt_sel_state;

    always_comb begin
        nxt_sel_state = sel_state_ff;
        if (!chip_reset_n_ff) begin
            nxt_sel_state = sel_reset; // [RULE_01] [RULE_09] [RULE_16]
        end else if (sel_wr) begin
            nxt_sel_state = sel_wr_data; // [RULE_03] [RULE_07] [RULE_14]
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_state_ff <= sel_reset; // [RULE_01] [RULE_09]
        end else begin
            sel_state_ff <= nxt_sel_state;
        end
    end

    // ------------------------------------------------------------
    // Clock output source
    // ------------------------------------------------------------
    logic buffered_clock_out_value;
    // The clock sources are foreign to sys_clk, so each passes two stages.
    logic [2:0] clk_src_meta_ff;
    logic [2:0] clk_src_sync_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_src_meta_ff <= '0;
            clk_src_sync_ff <= '0;
        end else begin
            clk_src_meta_ff <= {oscillator_clock, peripheral_bus_clock,
                master_system_clock};
            clk_src_sync_ff <= clk_src_meta_ff;
        end
    end

    always_comb begin
        case (sel_state_ff.buffered_clock_out_src) // [RULE_15]
            buffered_clock_out_master: buffered_clock_out_value = clk_src_sync_ff[0];
            buffered_clock_out_periph: buffered_clock_out_value = clk_src_sync_ff[1];
            buffered_clock_out_osc: buffered_clock_out_value = clk_src_sync_ff[2];
            default: buffered_clock_out_value = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    pad_drive_t [gpio_count-1:0] gpio_drive;
    pad_drive_t [gpio_count-1:0] nxt_pad_drive;
    logic b6_i2c;
    logic b1_i2c;

    assign b6_i2c = sel_state_ff.line6 == b6_i2c_data &&
        !sel_state_ff.line1_i2c_data; // [RULE_06]
    assign b1_i2c = sel_state_ff.line1_i2c_data; // [RULE_06]

    genvar gi;
    generate
        for (gi = 0; gi < gpio_count; gi++) begin : g_gpio
            assign gpio_drive[gi].out = gpio_out_data[gi];
            assign gpio_drive[gi].oe = gpio_dir_out[gi]; // [RULE_02]
        end
    endgenerate

    always_comb begin
        nxt_pad_drive = gpio_drive;
        // Open-drain pins only ever drive low.
        if (b1_i2c) begin
            nxt_pad_drive[idx_b1] = '{out: 1'b0, oe: i2c_data_oe};
        end
        case (sel_state_ff.line6)
            b6_serial_rx, b6_clock_in: begin
                nxt_pad_drive[idx_b6] = '{out: 1'b0, oe: 1'b0}; // [RULE_05]
            end
            b6_i2c_data: begin
                nxt_pad_drive[idx_b6] = '{out: 1'b0,
                    oe: b6_i2c && i2c_data_oe};
            end
            default: begin
            end
        endcase
        case (sel_state_ff.line7)
            b7_serial_tx: begin
                nxt_pad_drive[idx_b7] = '{out: serial_tx_data,
                    oe: !serial_single_wire || serial_tx_drive}; // [RULE_08]
            end
            b7_i2c_clock: begin
                nxt_pad_drive[idx_b7] = '{out: 1'b0, oe: i2c_clock_oe};
            end
            default: begin
            end
        endcase
        case (sel_state_ff.line4)
            b4_timer: nxt_pad_drive[idx_b4] = timer_zero_drive;
            b4_clock_out: nxt_pad_drive[idx_b4] = '{out: buffered_clock_out_value, oe: 1'b1};
            default: begin
            end
        endcase
        if (sel_state_ff.reset_pin_gpio) begin
            nxt_pad_drive[idx_a7] = '{out: 1'b0,
                oe: gpio_dir_out[idx_a7] && !gpio_out_data[idx_a7]}; // [RULE_12]
        end else begin
            nxt_pad_drive[idx_a7] = '{out: 1'b0, oe: 1'b0}; // [RULE_09]
        end
    end

    // ------------------------------------------------------------
    // Input routing
    // ------------------------------------------------------------
    logic nxt_serial_rx;
    logic nxt_i2c_data_in;
    logic nxt_ext_valid;

    always_comb begin
        nxt_serial_rx = 1'b1;
        if (sel_state_ff.line7 == b7_serial_tx && serial_single_wire) begin
            nxt_serial_rx = pad_sync_ff[idx_b7]; // [RULE_08]
        end else if (sel_state_ff.line6 == b6_serial_rx) begin
            nxt_serial_rx = pad_sync_ff[idx_b6];
        end
        nxt_i2c_data_in = 1'b1;
        if (b1_i2c) begin
            nxt_i2c_data_in = pad_sync_ff[idx_b1]; // [RULE_06]
        end else if (b6_i2c) begin
            nxt_i2c_data_in = pad_sync_ff[idx_b6];
        end
        nxt_ext_valid = sel_state_ff.line6 == b6_clock_in &&
            external_clock_mode_bit; // [RULE_04] [RULE_05]
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_drive_ff <= '0;
            gpio_in_ff <= '1;
            serial_rx_ff <= 1'b1;
            i2c_data_in_ff <= 1'b1;
            i2c_clock_in_ff <= 1'b1;
            timer_zero_in_ff <= 1'b0;
            external_clock_in_ff <= 1'b0;
            external_clock_valid_ff <= 1'b0;
        end else begin
            pad_drive_ff <= nxt_pad_drive;
            gpio_in_ff <= pad_sync_ff;
            serial_rx_ff <= nxt_serial_rx;
            i2c_data_in_ff <= nxt_i2c_data_in;
            i2c_clock_in_ff <= sel_state_ff.line7 == b7_i2c_clock ?
                pad_sync_ff[idx_b7] : 1'b1;
            timer_zero_in_ff <= sel_state_ff.line4 == b4_timer ?
                pad_sync_ff[idx_b4] : 1'b0;
            external_clock_in_ff <= nxt_ext_valid && pad_sync_ff[idx_b6];
            external_clock_valid_ff <= nxt_ext_valid;
        end
    end

endmodule

// >>> verification/pin_mux_checker.sv
// Port-level assertions for the pin-function multiplexer.
module pin_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic watchdog_reset,
    input wire logic software_reset,
    input wire pin_sel_t sel_wr_data,
    input wire logic sel_wr,
    input wire logic external_clock_mode_bit,
    input wire logic [gpio_count-1:0] pad_in,
    input wire pin_sel_t sel_state_ff,
    input wire pad_drive_t [gpio_count-1:0] pad_drive_ff,
    input wire logic external_clock_valid_ff,
    input wire logic chip_reset_n_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_sel_load;
        sel_wr && chip_reset_n_ff |=> sel_state_ff == $past(sel_wr_data);
    endproperty
    a_sel_load: assert property (p_sel_load)
        else $error("load");
    property p_sel_default;
        !chip_reset_n_ff |=> sel_state_ff == sel_reset;
    endproperty
    a_sel_default: assert property (p_sel_default)
        else $error("dflt");
    property p_a7_od;
        pad_drive_ff[idx_a7].oe |-> !pad_drive_ff[idx_a7].out;
    endproperty
    a_a7_od: assert property (p_a7_od)
        else $error("a7 high");
    property p_b6_in;
        sel_state_ff.line6 == b6_clock_in &&
            $past(sel_state_ff.line6) == b6_clock_in |-> !pad_drive_ff[idx_b6].oe;
    endproperty
    a_b6_in: assert property (p_b6_in)
        else $error("b6 oe");
    property p_clk_valid;
        !(sel_state_ff.line6 == b6_clock_in && external_clock_mode_bit) [*2]
            |-> !external_clock_valid_ff;
    endproperty
    a_clk_valid: assert property (p_clk_valid)
        else $error("valid");
    property p_rst_pin;
        (!sel_state_ff.reset_pin_gpio && !pad_in[idx_a7]) [*2]
            |-> ##[1:3] !chip_reset_n_ff;
    endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("pin");
    property p_gpio_keep;
        (sel_state_ff.reset_pin_gpio && chip_reset_n_ff && !watchdog_reset &&
            !software_reset) [*4] |=> chip_reset_n_ff;
    endproperty
    a_gpio_keep: assert property (p_gpio_keep)
        else $error("keep");
    property p_release;
        $rose(chip_reset_n_ff) |-> !$past(chip_reset_n_ff, rst_release_cycles);
    endproperty
    a_release: assert property (p_release)
        else $error("early");
    c_valid: cover property (external_clock_valid_ff);
    c_drop: cover property ($fell(chip_reset_n_ff));
    c_od: cover property (pad_drive_ff[idx_a7].oe);
endmodule

// >>> verification/pad_board.sv
// Board model: pin pull-ups and external parties pulling lines low.
module pad_board
    import pin_mux_pkg::*;
(
    input wire pad_drive_t [gpio_count-1:0] pad_drive,
    input wire logic [gpio_count-1:0] pull_low,
    output logic [gpio_count-1:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released pad floats up; a board pull-down wins over a driven high.
    always_comb begin
        for (int i = 0; i < gpio_count; i++) begin
            level[i] = (pad_drive[i].oe ? pad_drive[i].out : 1'b1) &
                ~pull_low[i];
        end
    end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the pin-function multiplexer.
module tb
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, reset_n = 1'b0, sel_wr = 1'b0;
    logic watchdog_reset = 1'b0, software_reset = 1'b0;
    logic external_clock_mode_bit = 1'b0, serial_tx_data = 1'b1;
    logic serial_single_wire = 1'b0, serial_tx_drive = 1'b1;
    logic i2c_data_oe = 1'b0, i2c_clock_oe = 1'b0;
    logic master_system_clock = 1'b0, peripheral_bus_clock = 1'b0;
    logic oscillator_clock = 1'b0;
    pin_sel_t sel_wr_data = sel_reset;
    pin_sel_t sel_state_ff;
    pad_drive_t timer_zero_drive = 2'b00;
    pad_drive_t [gpio_count-1:0] pad_drive_ff;
    logic [gpio_count-1:0] gpio_dir_out = 5'h00, gpio_out_data = 5'h00;
    logic [gpio_count-1:0] pull_low = 5'h00, pad_in, gpio_in_ff;
    logic serial_rx_ff, i2c_data_in_ff, i2c_clock_in_ff, timer_zero_in_ff;
    logic external_clock_in_ff, external_clock_valid_ff, chip_reset_n_ff;
    int mismatches = 0, checked = 0;

    reset_pin_function_mux dut_u (.sys_clk, .reset_n, .watchdog_reset,
        .software_reset, .sel_wr_data, .sel_wr, .external_clock_mode_bit,
        .gpio_dir_out, .gpio_out_data, .pad_in, .serial_tx_data,
        .serial_single_wire, .serial_tx_drive, .i2c_data_oe, .i2c_clock_oe,
        .timer_zero_drive, .master_system_clock, .peripheral_bus_clock,
        .oscillator_clock, .sel_state_ff, .pad_drive_ff, .gpio_in_ff,
        .serial_rx_ff, .i2c_data_in_ff, .i2c_clock_in_ff, .timer_zero_in_ff,
        .external_clock_in_ff, .external_clock_valid_ff, .chip_reset_n_ff);
    pad_board board_u (.pad_drive(pad_drive_ff), .pull_low, .level(pad_in));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Selection write: one-cycle strobe, then time for pads and synchronisers.
    task automatic write_sel(input pin_sel_t s);
        @(negedge sys_clk);
        sel_wr_data = s;
        sel_wr = 1'b1;
        @(negedge sys_clk);
        sel_wr = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic wait_chip(input logic lvl, output int n);
        n = 0;
        while (chip_reset_n_ff !== lvl && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        if (chip_reset_n_ff !== lvl) begin
            mismatches++;
            complete_run();
        end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        pin_sel_t s;
        logic [3:0] src;
        int n;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        wait_chip(1'b1, n);
        check("release", n >= rst_release_cycles, 1'b1);
        check("sel", sel_state_ff, sel_reset);
        check("b6", sel_state_ff.line6, b6_gpio);
        check("b7", sel_state_ff.line7, b7_gpio);
        check("b4", sel_state_ff.line4, b4_gpio);
        check("pin", sel_state_ff.reset_pin_gpio, 1'b0);
        $display("defaults done");
        gpio_dir_out = 5'h05;
        gpio_out_data = 5'h04;
        pull_low = 5'h08;
        repeat (5) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            check("oe", pad_drive_ff[i].oe, gpio_dir_out[i]);
        end
        check("gpio in", gpio_in_ff[3:0], 4'h6);
        $display("gpio done");
        s = sel_reset;
        s.line6 = b6_clock_in;
        pull_low = 5'h00;
        write_sel(s);
        check("valid", external_clock_valid_ff, 1'b0);
        check("b6 oe", pad_drive_ff[idx_b6].oe, 1'b0);
        external_clock_mode_bit = 1'b1;
        pull_low = 5'h04;
        repeat (5) @(negedge sys_clk);
        check("valid", external_clock_valid_ff, 1'b1);
        check("clk in", external_clock_in_ff, 1'b0);
        $display("clock in done");
        s = sel_reset;
        s.line1_i2c_data = 1'b1;
        s.line7 = b7_serial_tx;
        i2c_data_oe = 1'b1;
        serial_tx_data = 1'b0;
        write_sel(s);
        check("b1", pad_drive_ff[idx_b1], 2'b01);
        check("b7", pad_drive_ff[idx_b7], 2'b01);
        check("sda in", i2c_data_in_ff, 1'b0);
        serial_single_wire = 1'b1;
        serial_tx_drive = 1'b0;
        pull_low = 5'h08;
        repeat (5) @(negedge sys_clk);
        check("b7 oe", pad_drive_ff[idx_b7].oe, 1'b0);
        check("rx", serial_rx_ff, 1'b0);
        $display("serial done");
        s = sel_reset;
        s.line4 = b4_clock_out;
        s.line6 = b6_i2c_data;
        pull_low = 5'h00;
        for (int k = 0; k < 16; k++) begin
            s.buffered_clock_out_src = buffered_clock_out_src_t'(k[1:0]);
            master_system_clock = k[2];
            peripheral_bus_clock = ~k[2];
            oscillator_clock = k[3];
            src = {k[3], ~k[2], k[2], 1'b0};
            write_sel(s);
            check("buffered_clock_out", pad_drive_ff[idx_b4].out, src[k[1:0]]);
        end
        check("b6 sda", pad_drive_ff[idx_b6], 2'b01);
        $display("clock out done");
        s = sel_reset;
        s.line4 = b4_timer;
        s.line7 = b7_i2c_clock;
        s.line6 = b6_serial_rx;
        timer_zero_drive = 2'b11;
        i2c_clock_oe = 1'b1;
        pull_low = 5'h04;
        write_sel(s);
        check("b4 t0", pad_drive_ff[idx_b4], 2'b11);
        check("t0 in", timer_zero_in_ff, 1'b1);
        check("b7 scl", pad_drive_ff[idx_b7], 2'b01);
        check("scl in", i2c_clock_in_ff, 1'b0);
        check("b6 rx oe", pad_drive_ff[idx_b6].oe, 1'b0);
        check("rx b6", serial_rx_ff, 1'b0);
        check("sda idle", i2c_data_in_ff, 1'b1);
        $display("peripheral pins done");
        pull_low = 5'h10;
        wait_chip(1'b0, n);
        check("pin drop", n <= 5, 1'b1);
        write_sel(s);
        check("refused", sel_state_ff, sel_reset);
        pull_low = 5'h00;
        wait_chip(1'b1, n);
        check("release", n >= rst_release_cycles, 1'b1);
        s = sel_reset;
        s.reset_pin_gpio = 1'b1;
        gpio_dir_out = 5'h10;
        gpio_out_data = 5'h00;
        write_sel(s);
        check("a7 low", pad_drive_ff[idx_a7], 2'b01);
        check("a7 in", gpio_in_ff[idx_a7], 1'b0);
        gpio_out_data = 5'h10;
        pull_low = 5'h10;
        repeat (12) @(negedge sys_clk);
        check("a7 high", pad_drive_ff[idx_a7].oe, 1'b0);
        check("no rst", chip_reset_n_ff, 1'b1);
        pull_low = 5'h00;
        for (int j = 1; j < 3; j++) begin
            {software_reset, watchdog_reset} = 2'(j);
            wait_chip(1'b0, n);
            {software_reset, watchdog_reset} = 2'b00;
            @(negedge sys_clk);
            check("src rst", sel_state_ff, sel_reset);
            wait_chip(1'b1, n);
            write_sel(s);
        end
        $display("reset pin done");
        complete_run();
    end
endmodule

bind reset_pin_function_mux pin_mux_checker chk_u (.sys_clk, .reset_n,
    .watchdog_reset, .software_reset, .sel_wr_data, .sel_wr,
    .external_clock_mode_bit, .pad_in, .sel_state_ff, .pad_drive_ff,
    .external_clock_valid_ff, .chip_reset_n_ff);
